/* hw/tdp_top.sv */
// Touch decision, signal filters, position filters and event sequencer
`timescale 1ns/10ps
`include "tdp_map.svh"
module tdp_top #(
    parameter int N = 8,
    parameter int T = 2,
    parameter int MD = 5
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic meas_stb_i,
    input wire logic [N-1:0][11:0] sig_i,
    input wire logic [N-1:0][11:0] ref_i,
    input wire logic [N-1:0][7:0] thr_i,
    input wire logic grp_we_i,
    input wire logic [N-1:0][1:0] grp_i,
    input wire logic [N-1:0][1:0] gate_sel_i,
    input wire logic trigger_n_i,
    input wire logic [7:0] force_adc_i,
    input wire tdp_pkg::tdp_gate_cfg_type gate_cfg_i,
    input wire tdp_pkg::tdp_filt_cfg_type filt_cfg_i,
    input wire tdp_pkg::tdp_press_cfg_type press_cfg_i,
    input wire tdp_pkg::tdp_pos_cfg_type pos_cfg_i,
    input wire logic [T-1:0] touch_i,
    input wire logic [T-1:0][9:0] pos_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic [N-1:0] det_o,
    output logic [T-1:0][9:0] pos_o,
    output tdp_pkg::tdp_evt_type [T-1:0] press_evt_o,
    output tdp_pkg::tdp_evt_type [T-1:0] gest_evt_o
);
    typedef struct packed {
        logic [N-1:0][1:0] grp;
        logic [N-1:0][11:0] slew;
        logic [N-1:0][MD-1:0][11:0] hist;
        logic [N-1:0][11:0] iir;
        logic [N-1:0][7:0] cnt;
        logic [N-1:0] det;
        logic [7:0] adc;
        logic force_act;
        logic trig_act;
        logic [7:0] rd;
        logic [T-1:0] held;
        logic [T-1:0][9:0] pa;
        logic [T-1:0][9:0] po;
        logic [T-1:0][1:0] dir;
        logic [T-1:0][9:0] start;
        logic [T-1:0][9:0] anchor;
        logic [T-1:0][7:0] dur;
        logic [T-1:0][7:0] gap;
        logic [T-1:0][7:0] tmr;
        logic [T-1:0] moved;
        logic [T-1:0] tapped;
        tdp_pkg::tdp_press_state_type [T-1:0] ps;
        tdp_pkg::tdp_evt_type [T-1:0] pev;
        tdp_pkg::tdp_evt_type [T-1:0] gev;
    } tdp_state_type;

    tdp_state_type st_ff;
    tdp_state_type nxt_st;
    logic [N-1:0][11:0] slew_new;
    logic [N-1:0][MD-1:0][11:0] hist_new;
    logic [N-1:0][11:0] med;
    logic [N-1:0][11:0] dl;
    logic [N-1:0] above;
    logic [N-1:0] cand;
    logic [N-1:0] gok;
    logic [3:0] occ;
    logic [3:0] bv;
    logic [3:0][11:0] bd;
    logic [3:0][7:0] bi;
    logic force_ok;
    logic [T-1:0][9:0] px;
    logic [T-1:0][9:0] pn;
    logic [T-1:0][7:0] nt;
    logic [8:0] force_top;

    function automatic logic [11:0] absd12(logic [11:0] a, logic [11:0] b);
        absd12 = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [9:0] absd10(logic [9:0] a, logic [9:0] b);
        absd10 = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [11:0] delta(logic [11:0] s, logic [11:0] r);
        delta = (s > r) ? s - r : 12'h000;
    endfunction

    function automatic logic [11:0] slew_lim(logic [11:0] x, logic [11:0] y,
                                             logic [11:0] m);
        if (x > y && x - y > m) begin
            slew_lim = 12'(y + m);
        end else if (y > x && y - x > m) begin
            slew_lim = y - m;
        end else begin
            slew_lim = x;
        end
    endfunction

    function automatic logic [11:0] iir_upd(logic [11:0] x, logic [11:0] y,
                                            logic [1:0] k);
        logic signed [12:0] d;
        d = $signed({1'b0, x}) - $signed({1'b0, y});
        d = d >>> k;
        iir_upd = 12'($signed({1'b0, y}) + d);
    endfunction

    function automatic int grp_cnt(logic [N-1:0] d, logic [N-1:0][1:0] g,
                                   logic [1:0] w);
        grp_cnt = 0;
        for (int i = 0; i < N; i++) begin
            if (d[i] && g[i] == w) begin
                grp_cnt++;
            end
        end
    endfunction

    // Slew limit feeds the median window, the median feeds the low-pass
    always_comb begin
        for (int i = 0; i < N; i++) begin
            slew_new[i] = slew_lim(sig_i[i], st_ff.slew[i], filt_cfg_i.slew);
            hist_new[i] = {st_ff.hist[i][MD-2:0], slew_new[i]};
        end
    end

    for (genvar g = 0; g < N; g++) begin : g_med
        tdp_median #(
            .D(MD),
            .W(12)
        ) u_med (
            .vals_i(hist_new[g]),
            .len_i(filt_cfg_i.med_len),
            .med_o(med[g])
        );
    end

    assign force_top = 9'({1'b0, gate_cfg_i.force_thr} +
                          {1'b0, gate_cfg_i.force_hyst});

    always_comb begin
        nxt_st = st_ff;
        dl = '0;
        above = '0;
        cand = '0;
        gok = '0;
        occ = '0;
        bv = '0;
        bd = '0;
        bi = '0;
        force_ok = 1'b0;
        px = '0;
        pn = '0;
        nt = '0;
        for (int t = 0; t < T; t++) begin
            nxt_st.pev[t] = tdp_pkg::ev_none;
            nxt_st.gev[t] = tdp_pkg::ev_none;
        end
        if (grp_we_i) begin
            nxt_st.grp = grp_i;
        end
        // Status reads show the previous cycle's state
        if (rd_addr_i == `TDP_ADDR_ADC) begin
            nxt_st.rd = st_ff.adc;
        end else if (rd_addr_i == `TDP_ADDR_GATE) begin
            nxt_st.rd = 8'h00;
            nxt_st.rd[`TDP_GATE_TRIG_BIT] = st_ff.trig_act;
            nxt_st.rd[`TDP_GATE_FORCE_BIT] = st_ff.force_act;
        end else begin
            nxt_st.rd = 8'h00;
        end
        if (meas_stb_i) begin
            nxt_st.adc = force_adc_i;
            nxt_st.trig_act = !trigger_n_i && gate_cfg_i.trig_en;
            if (!st_ff.force_act &&
                force_adc_i < gate_cfg_i.force_thr) begin
                nxt_st.force_act = 1'b1;
            end else if (st_ff.force_act &&
                         {1'b0, force_adc_i} > force_top) begin
                nxt_st.force_act = 1'b0;
            end
            force_ok = nxt_st.force_act && gate_cfg_i.force_en;
            for (int i = 0; i < N; i++) begin
                nxt_st.slew[i] = slew_new[i];
                nxt_st.hist[i] = hist_new[i];
                nxt_st.iir[i] = iir_upd(med[i], st_ff.iir[i],
                                        filt_cfg_i.iir_k);
                dl[i] = delta(nxt_st.iir[i], ref_i[i]);
                above[i] = dl[i] > {4'h0, thr_i[i]};
                if (above[i]) begin
                    if (st_ff.cnt[i] != `TDP_CNT_MAX) begin
                        nxt_st.cnt[i] = st_ff.cnt[i] + 8'h01;
                    end
                end else begin
                    nxt_st.cnt[i] = 8'h00;
                    nxt_st.det[i] = 1'b0;
                end
                gok[i] = (gate_sel_i[i] == 2'h0) ||
                         (gate_sel_i[i][0] && nxt_st.trig_act) ||
                         (gate_sel_i[i][1] && force_ok);
                cand[i] = above[i] && gok[i] && !st_ff.det[i] &&
                          nxt_st.cnt[i] >= filt_cfg_i.integ_lim;
            end
            // Occupancy after releases, so a freed group reopens at once
            for (int i = 0; i < N; i++) begin
                if (nxt_st.det[i]) begin
                    occ[nxt_st.grp[i]] = 1'b1;
                end
            end
            for (int i = 0; i < N; i++) begin
                if (cand[i] && nxt_st.grp[i] != `TDP_GROUP_RST &&
                    (!bv[nxt_st.grp[i]] || dl[i] > bd[nxt_st.grp[i]])) begin
                    bv[nxt_st.grp[i]] = 1'b1;
                    bd[nxt_st.grp[i]] = dl[i];
                    bi[nxt_st.grp[i]] = 8'(i);
                end
            end
            // Object channels (group 0) bypass the lockout, so every object candidate detects
            for (int i = 0; i < N; i++) begin
                if (cand[i] && (nxt_st.grp[i] == `TDP_GROUP_RST ||
                    (!occ[nxt_st.grp[i]] &&
                     bi[nxt_st.grp[i]] == 8'(i)))) begin
                    nxt_st.det[i] = 1'b1;
                end
            end
            for (int t = 0; t < T; t++) begin
                px[t] = pos_cfg_i.screen ? pos_i[t] :
                        {2'h0, pos_i[t][7:0]};
                nt[t] = st_ff.tmr[t] + 8'h01;
                if (touch_i[t] && !st_ff.held[t]) begin
                    nxt_st.held[t] = 1'b1;
                    nxt_st.pa[t] = px[t];
                    nxt_st.po[t] = px[t];
                    nxt_st.dir[t] = 2'h0;
                    nxt_st.start[t] = px[t];
                    nxt_st.anchor[t] = px[t];
                    nxt_st.dur[t] = 8'h00;
                    nxt_st.moved[t] = 1'b0;
                    nxt_st.ps[t] = tdp_pkg::ps_short;
                    nxt_st.tmr[t] = 8'h00;
                end else if (touch_i[t]) begin
                    // Fast moves bypass smoothing; slow ones are averaged
                    if (absd10(px[t], st_ff.pa[t]) >= `TDP_ADAPT_FAST) begin
                        pn[t] = px[t];
                    end else begin
                        pn[t] = 10'($signed({1'b0, st_ff.pa[t]}) +
                                (($signed({1'b0, px[t]}) -
                                  $signed({1'b0, st_ff.pa[t]})) >>>
                                 pos_cfg_i.pf_rate));
                    end
                    nxt_st.pa[t] = pn[t];
                    if (st_ff.dir[t] == 2'h0 && pn[t] != st_ff.po[t]) begin
                        nxt_st.po[t] = pn[t];
                        nxt_st.dir[t] = (pn[t] > st_ff.po[t]) ? 2'h1 : 2'h2;
                    end else if (st_ff.dir[t] == 2'h1) begin
                        if (pn[t] > st_ff.po[t]) begin
                            nxt_st.po[t] = pn[t];
                        end else if (st_ff.po[t] - pn[t] >
                                     {2'h0, pos_cfg_i.pf_hyst}) begin
                            nxt_st.po[t] = pn[t];
                            nxt_st.dir[t] = 2'h2;
                        end
                    end else if (st_ff.dir[t] == 2'h2) begin
                        if (pn[t] < st_ff.po[t]) begin
                            nxt_st.po[t] = pn[t];
                        end else if (pn[t] - st_ff.po[t] >
                                     {2'h0, pos_cfg_i.pf_hyst}) begin
                            nxt_st.po[t] = pn[t];
                            nxt_st.dir[t] = 2'h1;
                        end
                    end
                    if (st_ff.dur[t] != `TDP_CNT_MAX) begin
                        nxt_st.dur[t] = st_ff.dur[t] + 8'h01;
                    end
                    if (absd10(pn[t], st_ff.start[t]) >= pos_cfg_i.move_thr) begin
                        nxt_st.moved[t] = 1'b1;
                    end
                    if (absd10(pn[t], st_ff.anchor[t]) >= pos_cfg_i.drag_thr) begin
                        nxt_st.gev[t] = tdp_pkg::ev_drag;
                        nxt_st.anchor[t] = pn[t];
                    end else if (!nxt_st.moved[t] &&
                                 nxt_st.dur[t] == pos_cfg_i.tap_time) begin
                        nxt_st.gev[t] = tdp_pkg::ev_press;
                    end
                    // Timers run even for disabled events, so spacing holds
                    unique case (st_ff.ps[t])
                        tdp_pkg::ps_idle: begin
                        end
                        tdp_pkg::ps_short: begin
                            nxt_st.tmr[t] = nt[t];
                            if (nt[t] >= press_cfg_i.short_dly) begin
                                if (press_cfg_i.en_short) begin
                                    nxt_st.pev[t] = tdp_pkg::ev_short;
                                end
                                nxt_st.ps[t] = tdp_pkg::ps_long;
                                nxt_st.tmr[t] = 8'h00;
                            end
                        end
                        tdp_pkg::ps_long: begin
                            nxt_st.tmr[t] = nt[t];
                            if (nt[t] >= press_cfg_i.long_dly) begin
                                if (press_cfg_i.en_long) begin
                                    nxt_st.pev[t] = tdp_pkg::ev_long;
                                end
                                nxt_st.ps[t] = tdp_pkg::ps_rep;
                                nxt_st.tmr[t] = 8'h00;
                            end
                        end
                        tdp_pkg::ps_rep, tdp_pkg::ps_run: begin
                            nxt_st.tmr[t] = nt[t];
                            if ((st_ff.ps[t] == tdp_pkg::ps_rep &&
                                 nt[t] >= press_cfg_i.rep_dly) ||
                                (st_ff.ps[t] == tdp_pkg::ps_run &&
                                 nt[t] >= press_cfg_i.rep_int)) begin
                                if (press_cfg_i.en_rep) begin
                                    nxt_st.pev[t] = tdp_pkg::ev_repeat;
                                end
                                nxt_st.ps[t] = tdp_pkg::ps_run;
                                nxt_st.tmr[t] = 8'h00;
                            end
                        end
                        default: begin
                            nxt_st.ps[t] = tdp_pkg::ps_idle;
                        end
                    endcase
                end else if (st_ff.held[t]) begin
                    nxt_st.held[t] = 1'b0;
                    nxt_st.ps[t] = tdp_pkg::ps_idle;
                    nxt_st.pev[t] = tdp_pkg::ev_release;
                    if (st_ff.dur[t] < pos_cfg_i.tap_time) begin
                        if (st_ff.moved[t]) begin
                            nxt_st.gev[t] = tdp_pkg::ev_flick;
                            nxt_st.tapped[t] = 1'b0;
                        end else if (st_ff.tapped[t] &&
                                     st_ff.gap[t] < pos_cfg_i.dtap_gap) begin
                            nxt_st.gev[t] = tdp_pkg::ev_dtap;
                            nxt_st.tapped[t] = 1'b0;
                        end else begin
                            nxt_st.gev[t] = tdp_pkg::ev_tap;
                            nxt_st.tapped[t] = 1'b1;
                            nxt_st.gap[t] = 8'h00;
                        end
                    end else begin
                        nxt_st.tapped[t] = 1'b0;
                    end
                end else if (st_ff.gap[t] != `TDP_CNT_MAX) begin
                    nxt_st.gap[t] = st_ff.gap[t] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_o = st_ff.rd;
    assign det_o = st_ff.det;
    assign pos_o = st_ff.po;
    assign press_evt_o = st_ff.pev;
    assign gest_evt_o = st_ff.gev;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_release;
        meas_stb_i && !touch_i[0] && st_ff.held[0];
    endsequence

    property p_release;
        s_release |=> st_ff.pev[0] == tdp_pkg::ev_release
            ##1 st_ff.pev[0] == tdp_pkg::ev_none;
    endproperty

    a_lock_single: assert property (
        grp_cnt(st_ff.det, st_ff.grp, 2'h1) <= 1 &&
        grp_cnt(st_ff.det, st_ff.grp, 2'h2) <= 1 &&
        grp_cnt(st_ff.det, st_ff.grp, 2'h3) <= 1)
        else $error("two detects in one lockout group");
    a_grp_reset: assert property (
        $past(!rstn_i) |-> st_ff.grp == '0)
        else $error("group not cleared by reset");
    a_gate_need: assert property (
        $rose(st_ff.det[0]) |-> $past(gok[0]))
        else $error("detect without open gate");
    a_trig_off: assert property (
        (meas_stb_i && gate_sel_i[0] == 2'h1 && !gate_cfg_i.trig_en)
        |=> !$rose(st_ff.det[0]))
        else $error("detect through disabled trigger");
    a_force_drop: assert property (
        $fell(st_ff.force_act) |-> $past({1'b0, force_adc_i} > force_top))
        else $error("force gate dropped inside hysteresis");
    a_integ_limit: assert property (
        $rose(st_ff.det[0]) |-> st_ff.cnt[0] >= $past(filt_cfg_i.integ_lim))
        else $error("detect before integration limit");
    a_integ_clear: assert property (
        (meas_stb_i && !above[0]) |=> st_ff.cnt[0] == 8'h00)
        else $error("counter kept below threshold");
    a_slew_clamp: assert property (
        meas_stb_i |=> absd12(st_ff.slew[0], $past(st_ff.slew[0])) <=
            $past(filt_cfg_i.slew))
        else $error("slew step too large");
    a_long_off: assert property (
        st_ff.pev[0] == tdp_pkg::ev_long |-> $past(press_cfg_i.en_long))
        else $error("long press while disabled");
    a_release_evt: assert property (p_release)
        else $error("release event missing");
endmodule

/* hw/tdp_map.svh */
// Map offsets, status bit positions and reset values of the post-processor
`ifndef TDP_MAP_SVH
`define TDP_MAP_SVH
`define TDP_ADDR_ADC 8'h1A
`define TDP_ADDR_GATE 8'h1B
`define TDP_GATE_TRIG_BIT 0
`define TDP_GATE_FORCE_BIT 1
`define TDP_GROUP_RST 2'h0
`define TDP_ADAPT_FAST 10'h020
`define TDP_CNT_MAX 8'hFF
`endif

/* hw/tdp_pkg.sv */
// Types shared by the touch post-processing block
package tdp_pkg;
    typedef enum logic [3:0] {
        ev_none, ev_short, ev_long, ev_repeat, ev_release,
        ev_tap, ev_dtap, ev_press, ev_flick, ev_drag
    } tdp_evt_type;
    typedef enum logic [2:0] {
        ps_idle, ps_short, ps_long, ps_rep, ps_run
    } tdp_press_state_type;
    typedef struct packed {
        logic trig_en;
        logic force_en;
        logic [7:0] force_thr;
        logic [7:0] force_hyst;
    } tdp_gate_cfg_type;
    typedef struct packed {
        logic [11:0] slew;
        logic [2:0] med_len;
        logic [1:0] iir_k;
        logic [7:0] integ_lim;
    } tdp_filt_cfg_type;
    typedef struct packed {
        logic [7:0] short_dly;
        logic [7:0] long_dly;
        logic [7:0] rep_dly;
        logic [7:0] rep_int;
        logic en_short;
        logic en_long;
        logic en_rep;
    } tdp_press_cfg_type;
    typedef struct packed {
        logic [7:0] tap_time;
        logic [7:0] dtap_gap;
        logic [9:0] move_thr;
        logic [9:0] drag_thr;
        logic [1:0] pf_rate;
        logic [7:0] pf_hyst;
        logic screen;
    } tdp_pos_cfg_type;
endpackage

/* hw/tdp_median.sv */
// Median of a programmable number of the newest samples
`timescale 1ns/10ps
module tdp_median #(
    parameter int D = 5,
    parameter int W = 12
) (
    input wire logic [D-1:0][W-1:0] vals_i,
    input wire logic [2:0] len_i,
    output logic [W-1:0] med_o
);
    logic [D-1:0][W-1:0] srt;
    logic [W-1:0] tmp;
    logic [W:0] pair;
    int n;

    always_comb begin
        srt = vals_i;
        tmp = '0;
        pair = '0;
        if (len_i == 3'h0) begin
            n = 1;
        end else if (int'(len_i) > D) begin
            n = D;
        end else begin
            n = int'(len_i);
        end
        // Only the first n slots take part in the sort
        for (int a = 0; a < D; a++) begin
            for (int b = 0; b < D - 1; b++) begin
                if (b + 1 < n && srt[b] > srt[b+1]) begin
                    tmp = srt[b];
                    srt[b] = srt[b+1];
                    srt[b+1] = tmp;
                end
            end
        end
        if (n % 2 == 1) begin
            med_o = srt[n/2];
        end else begin
            pair = {1'b0, srt[n/2-1]} + {1'b0, srt[n/2]};
            med_o = pair[W:1];
        end
    end
endmodule

/* verification/tdp_host_model.sv */
// Host side model that polls the status map
`timescale 1ns/10ps
module tdp_host_model (
    input wire logic core_clk_i,
    input wire logic [7:0] rd_data_i,
    output logic [7:0] rd_addr_o
);
    initial rd_addr_o = 8'h00;
    // Data is registered, so it is taken one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        rd_addr_o = a;
        @(negedge core_clk_i);
        d = rd_data_i;
        rd_addr_o = ~a;
    endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the touch post-processor
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rstn = 0, stb = 0, we = 0, trg_n = 1;
    logic [7:0][11:0] sig = '0;
    logic [7:0][1:0] grp = '0, gsel = '0;
    logic [7:0] adc = 8'h00, ra, rd, rv, det;
    logic [7:0] av[3] = '{8'h30, 8'h48, 8'h60}, gv[3] = '{2, 2, 0};
    logic [1:0] tch = 2'h0;
    tdp_pkg::tdp_gate_cfg_type gcfg = '0;
    tdp_pkg::tdp_filt_cfg_type fcfg = '{12'hFFF, 3'h1, 2'h0, 8'h03};
    tdp_pkg::tdp_press_cfg_type pcfg = '{2, 2, 2, 2, 1'b1, 1'b0, 1'b1};
    tdp_pkg::tdp_evt_type [1:0] pev;
    tdp_pkg::tdp_evt_type [1:0] gev;
    tdp_pkg::tdp_evt_type evq[$];
    tdp_pkg::tdp_evt_type gq[$];
    tdp_pkg::tdp_pos_cfg_type pcf = '0;
    logic [1:0][9:0] pos = '0, po;
    int err_total = 0, cmp_count = 0;
    // Wide slew, single-tap median and k=0 make the filters transparent
    tdp_top dut_u (.core_clk_i(clk), .rstn_i(rstn), .meas_stb_i(stb),
        .sig_i(sig), .ref_i('0), .thr_i({8{8'h10}}), .grp_we_i(we),
        .grp_i(grp), .gate_sel_i(gsel), .trigger_n_i(trg_n),
        .force_adc_i(adc), .gate_cfg_i(gcfg), .filt_cfg_i(fcfg),
        .press_cfg_i(pcfg), .pos_cfg_i(pcf), .touch_i(tch), .pos_i(pos),
        .rd_addr_i(ra), .rd_data_o(rd), .det_o(det), .pos_o(po),
        .press_evt_o(pev), .gest_evt_o(gev));
    tdp_host_model host_u (.core_clk_i(clk), .rd_data_i(rd),
        .rd_addr_o(ra));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic strobe(input int n);
        repeat (n) begin
            @(negedge clk) stb = 1'b1;
            @(negedge clk) stb = 1'b0;
            if (pev[0] != tdp_pkg::ev_none) evq.push_back(pev[0]);
            if (gev[1] != tdp_pkg::ev_none) gq.push_back(gev[1]);
        end
    endtask
    task automatic conclude;
        $display("compares=%0d errors=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        host_u.rd(8'h55, rv);
        chk(rv, 8'h00);
        sig[0] = 12'h030;
        sig[1] = 12'h030;
        strobe(2);
        chk(det, 8'h00);
        strobe(1);
        chk(det, 8'h03);
        sig[0] = 12'h000;
        strobe(1);
        chk(det, 8'h02);
        sig[0] = 12'h030;
        strobe(2);
        chk(det, 8'h02);
        // Lockout on ch0/ch1, integration of one strobe
        fcfg.integ_lim = 8'h01;
        grp[1:0] = 4'h5;
        @(negedge clk) we = 1'b1;
        @(negedge clk) we = 1'b0;
        sig = '0;
        strobe(1);
        sig[0] = 12'h030;
        sig[1] = 12'h040;
        strobe(1);
        chk(det, 8'h02);
        sig[0] = 12'h050;
        strobe(1);
        chk(det, 8'h02);
        sig[1] = 12'h000;
        strobe(1);
        chk(det, 8'h01);
        sig = '0;
        strobe(1);
        sig[0] = 12'h030;
        gsel[0] = 2'h1;
        trg_n = 1'b0;
        strobe(1);
        chk(det, 8'h00);
        gcfg.trig_en = 1'b1;
        strobe(1);
        chk(det, 8'h01);
        trg_n = 1'b1;
        gcfg = '{1'b1, 1'b1, 8'h40, 8'h10};
        foreach (av[k]) begin
            adc = av[k];
            strobe(1);
            host_u.rd(8'h1B, rv);
            chk(rv, gv[k]);
        end
        host_u.rd(8'h1A, rv);
        chk(rv, 8'h60);
        fcfg.slew = 12'h008;
        sig[3] = 12'h030;
        strobe(2);
        chk(det[3], 1'b0);
        strobe(1);
        chk(det[3], 1'b1);
        fcfg = '{12'hFFF, 3'h3, 2'h0, 8'h01};
        sig[4] = 12'h030;
        strobe(1);
        chk(det[4], 1'b0);
        strobe(1);
        chk(det[4], 1'b1);
        fcfg.med_len = 3'h2;
        sig[5] = 12'h01E;
        strobe(1);
        chk(det[5], 1'b0);
        strobe(1);
        chk(det[5], 1'b1);
        fcfg = '{12'hFFF, 3'h1, 2'h1, 8'h01};
        sig[6] = 12'h01C;
        strobe(1);
        chk(det[6], 1'b0);
        strobe(1);
        chk(det[6], 1'b1);
        evq.delete();
        tch = 2'h1;
        strobe(12);
        tch = 2'h0;
        strobe(1);
        chk({4'h0, evq[0]}, 8'h01);
        chk({4'h0, evq[1]}, 8'h03);
        chk({4'h0, evq[2]}, 8'h03);
        chk({4'h0, evq[$]}, 8'h04);
        pcf = '{8'h04, 8'h04, 10'h010, 10'h040, 2'h1, 8'h08, 1'b1};
        pos[1] = 10'h100;
        tch = 2'h2;
        strobe(1);
        chk(po[1], 16'h0100);
        pos[1] = 10'h108;
        strobe(1);
        chk(po[1], 16'h0104);
        pos[1] = 10'h100;
        strobe(1);
        chk(po[1], 16'h0104);
        pos[1] = 10'h0E0;
        strobe(1);
        chk(po[1], 16'h00E0);
        // Flick, tap and double tap, then press and drag
        repeat (3) begin
            tch = 2'h0;
            strobe(1);
            tch = 2'h2;
            strobe(1);
        end
        strobe(4);
        pos[1] = 10'h120;
        strobe(1);
        tch = 2'h0;
        strobe(1);
        chk({4'h0, pev[1]}, 8'h04);
        chk({4'h0, gq[0]}, 8'h08);
        chk({4'h0, gq[1]}, 8'h05);
        chk({4'h0, gq[2]}, 8'h06);
        chk({4'h0, gq[3]}, 8'h07);
        chk({4'h0, gq[4]}, 8'h09);
        conclude();
    end
endmodule
